//--- pkg/iscl_consts.vh
`ifndef ISCL_CONSTS_VH
`define ISCL_CONSTS_VH
// Overview of operation
// - standard speed: high phase from standard high count
// - standard speed: low phase from standard low count
// - fast speed: high phase from fast high count
// - fast speed: low phase from fast low count
// - high-speed preamble phases use the fast counts
// - count writes accepted only while controller off
// - high counts below 6 stored as 6
// - low counts below 8 stored as 8
// - 16-bit idle counter flags at std high+10
`define ISCL_OFS_STD_HIGH 32'h5000_1514
`define ISCL_OFS_STD_LOW 32'h5000_1518
`define ISCL_OFS_FAST_HIGH 32'h5000_151C
`define ISCL_OFS_FAST_LOW 32'h5000_1520
`define ISCL_RST_STD_HIGH 16'h0048
`define ISCL_RST_STD_LOW 16'h004F
`define ISCL_RST_FAST_HIGH 16'h0008
`define ISCL_RST_FAST_LOW 16'h0017
`define ISCL_MIN_HIGH 16'h0006
`define ISCL_MIN_LOW 16'h0008
`define ISCL_IDLE_MARGIN 16'h000A
`define ISCL_SPEED_STD 2'h1
`define ISCL_SPEED_FAST 2'h2
`define ISCL_SPEED_HIGH 2'h3
`endif

//--- logic/iscl_clamp.v
`timescale 1ns/1ps
// computes a write value with a floor applied
module iscl_clamp (
  input wire [15:0] value_i,
  input wire [15:0] floor_i,
  output wire [15:0] result_o
);
  assign result_o = (value_i < floor_i) ? floor_i : value_i;
endmodule // iscl_clamp

//--- logic/iscl_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module iscl_sync (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire d_i,
  output wire q_o
);
  reg meta_ff;
  reg q_ff;
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_ff <= 1'b1;
      q_ff <= 1'b1;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end
  assign q_o = q_ff;
endmodule // iscl_sync

//--- logic/iscl_period_counts.v
`timescale 1ns/1ps
`include "iscl_consts.vh"
module iscl_period_counts (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [31:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [1:0] reg_be_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  input wire controller_on_bit_i,
  input wire [1:0] speed_i,
  input wire hs_preamble_i,
  input wire scl_run_i,
  input wire scl_pin_i,
  input wire sda_pin_i,
  output wire scl_o,
  output wire scl_oe_o,
  output wire bus_idle_o,
  output wire [15:0] cur_high_count_o,
  output wire [15:0] cur_low_count_o
);
  reg [15:0] std_high_period_field_ff;
  reg [15:0] std_low_period_field_ff;
  reg [15:0] fast_high_period_field_ff;
  reg [15:0] fast_low_period_field_ff;
  reg [7:0] fast_low_byte_ff;
  reg [15:0] phase_cnt_ff;
  reg scl_low_ff;
  reg [15:0] idle_cnt_ff;
  reg idle_ff;
  reg scl_prev_ff;
  reg sda_prev_ff;
  wire scl_s;
  wire sda_s;
  wire [15:0] std_high_cl;
  wire [15:0] std_low_cl;
  wire [15:0] fast_high_cl;
  wire [15:0] fast_low_cl;
  wire [15:0] fast_low_word;
  wire wr_ok;
  wire use_fast;
  wire [15:0] high_sel;
  wire [15:0] low_sel;
  wire [15:0] idle_lim;
  wire bus_edge;

  iscl_sync u_sync_scl (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i(scl_pin_i),
    .q_o(scl_s)
  );
  iscl_sync u_sync_sda (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .d_i(sda_pin_i),
    .q_o(sda_s)
  );

  // full-word writes clamp directly; byte writes to fast low assemble first
  assign fast_low_word = reg_be_i[0] ? {reg_wdata_i[15:8], reg_wdata_i[7:0]}
                                     : {reg_wdata_i[15:8], fast_low_byte_ff};
  iscl_clamp u_cl_sh (.value_i(reg_wdata_i), .floor_i(`ISCL_MIN_HIGH), .result_o(std_high_cl));
  iscl_clamp u_cl_sl (.value_i(reg_wdata_i), .floor_i(`ISCL_MIN_LOW), .result_o(std_low_cl));
  iscl_clamp u_cl_fh (.value_i(reg_wdata_i), .floor_i(`ISCL_MIN_HIGH), .result_o(fast_high_cl));
  iscl_clamp u_cl_fl (.value_i(fast_low_word), .floor_i(`ISCL_MIN_LOW), .result_o(fast_low_cl));

  assign wr_ok = reg_wr_i & ~controller_on_bit_i;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      std_high_period_field_ff <= `ISCL_RST_STD_HIGH;
      std_low_period_field_ff <= `ISCL_RST_STD_LOW;
      fast_high_period_field_ff <= `ISCL_RST_FAST_HIGH;
      fast_low_period_field_ff <= `ISCL_RST_FAST_LOW;
      fast_low_byte_ff <= 8'h17;
    end else if (wr_ok) begin
      case (reg_addr_i)
        `ISCL_OFS_STD_HIGH: std_high_period_field_ff <= std_high_cl;
        `ISCL_OFS_STD_LOW: std_low_period_field_ff <= std_low_cl;
        `ISCL_OFS_FAST_HIGH: fast_high_period_field_ff <= fast_high_cl;
        `ISCL_OFS_FAST_LOW: begin
          // lower byte only is held aside until the upper byte lands
          if (reg_be_i == 2'h1) begin
            fast_low_byte_ff <= reg_wdata_i[7:0];
          end else if (reg_be_i[1]) begin
            fast_low_period_field_ff <= fast_low_cl;
            fast_low_byte_ff <= fast_low_word[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  always @* begin
    case (reg_addr_i)
      `ISCL_OFS_STD_HIGH: reg_rdata_o = std_high_period_field_ff;
      `ISCL_OFS_STD_LOW: reg_rdata_o = std_low_period_field_ff;
      `ISCL_OFS_FAST_HIGH: reg_rdata_o = fast_high_period_field_ff;
      `ISCL_OFS_FAST_LOW: reg_rdata_o = fast_low_period_field_ff;
      default: reg_rdata_o = 16'h0000;
    endcase
  end

  // high speed outside the preamble selects the standard counts here; only its preamble selects the fast counts
  assign use_fast = (speed_i == `ISCL_SPEED_FAST) |
                    ((speed_i == `ISCL_SPEED_HIGH) & hs_preamble_i);
  assign high_sel = use_fast ? fast_high_period_field_ff : std_high_period_field_ff;
  assign low_sel = use_fast ? fast_low_period_field_ff : std_low_period_field_ff;
  assign cur_high_count_o = high_sel;
  assign cur_low_count_o = low_sel;

  // each phase lasts exactly its count of controller cycles
  always @(posedge clk_sys_i) begin
    if (sys_rst_i | ~scl_run_i) begin
      phase_cnt_ff <= 16'h0001;
      scl_low_ff <= 1'b0;
    end else if (phase_cnt_ff >= (scl_low_ff ? low_sel : high_sel)) begin
      phase_cnt_ff <= 16'h0001;
      scl_low_ff <= ~scl_low_ff;
    end else begin
      phase_cnt_ff <= phase_cnt_ff + 16'h0001;
    end
  end
  // open drain: only drive the line low
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_run_i & scl_low_ff;

  // any bus edge or scl low restarts the idle count; relies on hcnt <= 65525
  assign idle_lim = std_high_period_field_ff + `ISCL_IDLE_MARGIN;
  assign bus_edge = (scl_s ^ scl_prev_ff) | (sda_s ^ sda_prev_ff) | ~scl_s;
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      idle_cnt_ff <= 16'h0000;
      idle_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      if (bus_edge) begin
        idle_cnt_ff <= 16'h0000;
        idle_ff <= 1'b0;
      end else if (idle_cnt_ff >= idle_lim) begin
        idle_ff <= 1'b1;
      end else begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end
    end
  end
  assign bus_idle_o = idle_ff;
endmodule // iscl_period_counts

//--- bench/iscl_period_counts_assertions.sv
`timescale 1ns/1ps
`include "iscl_consts.vh"
module iscl_chk (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire controller_on_bit_i,
  input wire hs_preamble_i,
  input wire scl_oe_o,
  input wire bus_idle_o,
  input wire [1:0] speed_i,
  input wire [31:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  input wire [15:0] cur_high_count_o,
  input wire [15:0] cur_low_count_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire ok = reg_wr_i && !controller_on_bit_i;
  // fast high count shown on the read port but not selected
  wire fh_off = reg_addr_i == `ISCL_OFS_FAST_HIGH && cur_high_count_o != reg_rdata_o;
  chk_write_locked:
    assert property (reg_wr_i && controller_on_bit_i ##1 $stable(speed_i) && $stable(hs_preamble_i) |->
      $stable({cur_high_count_o, cur_low_count_o}))
      else $error("locked write took effect");
  chk_high_floor:
    assert property (ok && reg_addr_i == `ISCL_OFS_STD_HIGH ##1 reg_addr_i == `ISCL_OFS_STD_HIGH |->
      reg_rdata_o == ($past(reg_wdata_i) < `ISCL_MIN_HIGH ? `ISCL_MIN_HIGH : $past(reg_wdata_i))) else $error("high floor");
  chk_low_floor:
    assert property (ok && reg_addr_i == `ISCL_OFS_STD_LOW ##1 reg_addr_i == `ISCL_OFS_STD_LOW |->
      reg_rdata_o == ($past(reg_wdata_i) < `ISCL_MIN_LOW ? `ISCL_MIN_LOW : $past(reg_wdata_i))) else $error("low floor");
  chk_std_select:
    assert property (speed_i == `ISCL_SPEED_STD && reg_addr_i == `ISCL_OFS_STD_HIGH |-> cur_high_count_o == reg_rdata_o)
      else $error("std pair");
  chk_fast_select:
    assert property (speed_i == `ISCL_SPEED_FAST |-> !fh_off) else $error("fast pair");
  chk_hs_preamble:
    assert property (speed_i == `ISCL_SPEED_HIGH && hs_preamble_i |-> !fh_off) else $error("preamble pair");
  chk_idle_drop:
    assert property ($rose(scl_oe_o) |-> ##[1:6] !bus_idle_o) else $error("idle stuck");
  chk_idle_early:
    assert property ($rose(bus_idle_o) |-> !$past(scl_oe_o, 8)) else $error("idle early");
  cover property (ok);
  cover property (reg_wr_i && controller_on_bit_i);
  cover property ($rose(bus_idle_o));
endmodule // iscl_chk
bind iscl_period_counts iscl_chk i_iscl_chk (.*);

//--- bench/iscl_bus_peer.sv
`timescale 1ns/1ps
module iscl_bus_peer (
  input wire scl_oe_i,
  input wire busy_i,
  output wire scl_pin_o,
  output wire sda_pin_o
);
  reg lk = 1'b0;
  // another master's clock, still unless it owns the bus
  always #80 lk = busy_i && !lk;
  assign scl_pin_o = !scl_oe_i && !lk;
  assign sda_pin_o = 1'b1;
endmodule // iscl_bus_peer

//--- bench/iscl_period_counts_test.sv
`timescale 1ns/1ps
`include "iscl_consts.vh"
module iscl_period_counts_test;
  reg clk_sys_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, controller_on_bit_i = 1'b0, hs_preamble_i = 1'b0;
  reg scl_run_i = 1'b0, busy = 1'b0;
  reg [1:0] reg_be_i = 2'h3, speed_i = `ISCL_SPEED_STD;
  reg [31:0] reg_addr_i = 32'h0;
  reg [15:0] reg_wdata_i = 16'h0;
  wire scl_pin_i, sda_pin_i, scl_o, scl_oe_o, bus_idle_o;
  wire [15:0] reg_rdata_o, cur_high_count_o, cur_low_count_o;
  integer bad_count = 0, n_compared = 0, i, j, n;
  always #5 clk_sys_i = !clk_sys_i;
  iscl_period_counts i_iscl_period_counts (.*);
  iscl_bus_peer i_iscl_bus_peer (.scl_oe_i(scl_oe_o), .busy_i(busy), .scl_pin_o(scl_pin_i), .sda_pin_o(sda_pin_i));
  task summarize;
    begin
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [15:0] exp, input [15:0] got);
    begin
      n_compared++;
      if (got !== exp) begin
        bad_count++;
        $display("[FAIL] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [31:0] a, input [1:0] be, input [15:0] d);
    begin
      reg_addr_i <= a;
      reg_be_i <= be;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task rd(input [31:0] a, input [15:0] exp);
    begin
      reg_addr_i <= a;
      #1 chk("rdata", exp, reg_rdata_o);
      @(posedge clk_sys_i);
    end
  endtask
  // a phase that never ends is a mismatch and closes the run
  task tmo;
    begin
      bad_count++;
      $display("[FAIL] scl_phase exp bounded got timeout");
      summarize;
    end
  endtask
  // length of the next whole phase in which the pull-down equals v
  task meas(input v, output integer c);
    begin
      c = 0;
      for (i = 0; i < 400 && scl_oe_o === v; i++) @(posedge clk_sys_i) #1;
      if (i >= 400) tmo;
      for (i = 0; i < 400 && scl_oe_o !== v; i++) @(posedge clk_sys_i) #1;
      if (i >= 400) tmo;
      for (i = 0; i < 400 && scl_oe_o === v; i++) @(posedge clk_sys_i) #1 c++;
      if (i >= 400) tmo;
      @(posedge clk_sys_i);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(`ISCL_OFS_STD_HIGH, `ISCL_RST_STD_HIGH);
    rd(`ISCL_OFS_STD_LOW, `ISCL_RST_STD_LOW);
    rd(`ISCL_OFS_FAST_HIGH, `ISCL_RST_FAST_HIGH);
    rd(`ISCL_OFS_FAST_LOW, `ISCL_RST_FAST_LOW);
    rd(32'h5000_1524, 16'h0000);
    wr(`ISCL_OFS_STD_HIGH, 2'h3, 16'h0005);
    rd(`ISCL_OFS_STD_HIGH, 16'h0006);
    wr(`ISCL_OFS_STD_LOW, 2'h3, 16'h000A);
    wr(`ISCL_OFS_FAST_HIGH, 2'h3, 16'h0009);
    wr(`ISCL_OFS_FAST_LOW, 2'h1, 16'h0005);
    rd(`ISCL_OFS_FAST_LOW, `ISCL_RST_FAST_LOW);
    wr(`ISCL_OFS_FAST_LOW, 2'h2, 16'h0000);
    rd(`ISCL_OFS_FAST_LOW, 16'h0008);
    controller_on_bit_i <= 1'b1;
    wr(`ISCL_OFS_STD_HIGH, 2'h3, 16'h0020);
    rd(`ISCL_OFS_STD_HIGH, 16'h0006);
    scl_run_i <= 1'b1;
    chk("scl_o", 16'h0000, {15'h0, scl_o});
    for (j = 1; j < 4; j++) begin
      speed_i <= j[1:0];
      hs_preamble_i <= (j == 3);
      rd(`ISCL_OFS_FAST_HIGH, 16'h0009);
      chk("cur_high", j == 1 ? 16'h0006 : 16'h0009, cur_high_count_o);
      chk("cur_low", j == 1 ? 16'h000A : 16'h0008, cur_low_count_o);
      meas(1'b0, n);
      chk("scl_high", j == 1 ? 16'h0006 : 16'h0009, n[15:0]);
      meas(1'b1, n);
      chk("scl_low", j == 1 ? 16'h000A : 16'h0008, n[15:0]);
    end
    scl_run_i <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    busy <= 1'b1;
    #1 chk("idle", 16'h0001, {15'h0, bus_idle_o});
    repeat (40) @(posedge clk_sys_i);
    #1 chk("busy", 16'h0000, {15'h0, bus_idle_o});
    busy <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(`ISCL_OFS_STD_HIGH, `ISCL_RST_STD_HIGH);
    rd(`ISCL_OFS_FAST_LOW, `ISCL_RST_FAST_LOW);
    summarize;
  end
endmodule // iscl_period_counts_test
